/* spl_defines.svh */
/*
  Offsets, field positions, reset values and ordered-set counts of the port
  link control register. Assumes inclusion by bare name from every
  design module.
*/
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH

// ============================================================
// Register map
`define SPL_ADDR_W          12
`define SPL_LINK_CTL_OFFSET 12'h0d0
`define SPL_LINK_CTL_RESET  16'h0000

// ============================================================
// Field positions
`define SPL_BIT_ASPM_LO     0
`define SPL_BIT_RCB         3
`define SPL_BIT_LINK_DIS    4
`define SPL_BIT_RETRAIN     5
`define SPL_BIT_COMMON_CLK  6
`define SPL_BIT_EXT_SYNCH   7
`define SPL_BIT_HW_WIDTH    9
`define SPL_BIT_BW_MGMT_IE  10
`define SPL_BIT_AUTO_BW_IE  11

// ============================================================
// Ordered-set counts for leaving low-power states
`define SPL_EXT_FTS_COUNT   4096
`define SPL_EXT_TS1_COUNT   1024
`define SPL_NORM_FTS_COUNT  255
`define SPL_NORM_TS1_COUNT  16

// ============================================================
// AXI4-Lite responses
`define SPL_RESP_OKAY       2'h0
`define SPL_RESP_DECERR     2'h3

`endif

/* spl_pkg.sv */
/*
  Types of the port link control block: register layout, low-power control
  encoding and the one-hot state machine states.
  Assumes spl_defines.svh is on the include path.
*/
package spl_pkg;

  // ============================================================
  // Register layout
  typedef struct packed {
    logic [3:0] rsvd_15_12;
    logic       auto_bw_ie;
    logic       bw_mgmt_ie;
    logic       hw_width_dis;
    logic       rsvd_8;
    logic       ext_synch;
    logic       common_clk;
    logic       retrain;
    logic       link_disable;
    logic       rcb;
    logic       rsvd_2;
    logic [1:0] aspm;
  } spl_link_ctl_s;

  // ============================================================
  // Low-power entry control encoding
  typedef enum logic [1:0] {
    SPL_ASPM_OFF  = 2'h0,
    SPL_ASPM_L0S  = 2'h1,
    SPL_ASPM_L1   = 2'h2,
    SPL_ASPM_BOTH = 2'h3
  } spl_aspm_e;

  // ============================================================
  // One-hot states
  typedef enum logic [1:0] {
    SPL_IDLE = 2'b01,
    SPL_BUSY = 2'b10
  } spl_state_e;

endpackage : spl_pkg

/* spl_hold.sv */
/*
  One-entry holding register for an AXI4-Lite request channel.
  Assumes the consumer pulses release_i once it has used the held payload.
*/
`include "spl_defines.svh"

module spl_hold
  import spl_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // Channel
  input  wire logic             valid_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic                  ready_o,
  // Consumer
  input  wire logic             release_i,
  output logic                  held_o,
  output logic [WIDTH-1:0]      data_o
);

  initial
  begin
    if (WIDTH < 1) $error("spl_hold: WIDTH must be positive");
  end

  // ============================================================
  // Hold flag and ready
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      held_o  <= 1'b0;
      ready_o <= 1'b1;
    end
    else if (valid_i && ready_o)
    begin
      held_o  <= 1'b1;
      ready_o <= 1'b0;
    end
    else if (release_i)
    begin
      held_o  <= 1'b0;
      ready_o <= 1'b1;
    end
  end

  // ============================================================
  // Payload
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      data_o <= '0;
    else if (valid_i && ready_o)
      data_o <= data_i;
  end

endmodule : spl_hold

/* spl_os_seq.sv */
/*
  Ordered-set burst sequencer used when the link leaves L0s or L1.
  Assumes the link logic pulses a request and accepts one set per os_ready_i.
*/
`include "spl_defines.svh"

module spl_os_seq
  import spl_pkg::*;
#(
  parameter int NORM_FTS = `SPL_NORM_FTS_COUNT,
  parameter int NORM_TS1 = `SPL_NORM_TS1_COUNT
)
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Requests
  input  wire logic ext_synch_i,
  input  wire logic exit_l0s_i,
  input  wire logic exit_l1_i,
  // Ordered-set stream
  input  wire logic os_ready_i,
  output logic      os_valid_o,
  output logic      os_is_ts1_o
);

  initial
  begin
    if (NORM_FTS < 1 || NORM_FTS > 8191) $error("spl_os_seq: NORM_FTS out of range");
    if (NORM_TS1 < 1 || NORM_TS1 > 8191) $error("spl_os_seq: NORM_TS1 out of range");
  end

  spl_state_e  state_ff;
  logic [12:0] left_ff;

  // ============================================================
  // Burst length select and countdown
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff    <= SPL_IDLE;
      left_ff     <= 13'h0000;
      os_valid_o  <= 1'b0;
      os_is_ts1_o <= 1'b0;
    end
    else
    begin
      case (state_ff)
        SPL_IDLE:
        begin
          if (exit_l0s_i || exit_l1_i)
          begin
            state_ff    <= SPL_BUSY;
            os_valid_o  <= 1'b1;
            os_is_ts1_o <= !exit_l0s_i;
            if (exit_l0s_i)
              left_ff <= ext_synch_i ? 13'(`SPL_EXT_FTS_COUNT) : 13'(NORM_FTS); // [R10]
            else
              left_ff <= ext_synch_i ? 13'(`SPL_EXT_TS1_COUNT) : 13'(NORM_TS1); // [R10]
          end
        end
        SPL_BUSY:
        begin
          if (os_ready_i)
          begin
            left_ff <= left_ff - 13'h0001;
            if (left_ff == 13'h0001)
            begin
              state_ff   <= SPL_IDLE;
              os_valid_o <= 1'b0;
            end
          end
        end
        default:
        begin
          state_ff   <= SPL_IDLE;
          os_valid_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : spl_os_seq

/* spl_link_ctl.sv */
/*
  Port link control register with its AXI4-Lite slave and the link-side
  controls that it drives.
  Assumes a single clock, synchronous link-side inputs and an AXI4-Lite
  master that holds valid and payload until taken.
*/
// Chosen here: the AXI4-Lite interface to the registers.
//
// Contract
// [R1] Low-power field: 00 none, 01 L0s, 10 L1, 11 both
// [R2] Receiver may always enter L0s
// [R3] Completion boundary bit always reads zero
// [R4] Upstream link disable bit hardwired zero
// [R5] Downstream link disable holds link down while set
// [R6] Upstream retrain bit hardwired zero
// [R7] Downstream retrain write of one starts retraining
// [R8] Retrain bit always reads zero
// [R9] Common clock bit stored and returned
// [R10] Extended synch: 4096 FTS, 1024 TS1 sets
// [R11] Interrupt enables read-only upstream, writable downstream
// [R12] Reserved bits 2, 8, 15:12 read zero
// [R13] All fields zero after reset
`include "spl_defines.svh"

module spl_link_ctl
  import spl_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0,
  parameter int NORM_FTS    = `SPL_NORM_FTS_COUNT,
  parameter int NORM_TS1    = `SPL_NORM_TS1_COUNT
)
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  // AXI4-Lite write address
  input  wire logic [`SPL_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]             s_axi_awprot_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [`SPL_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]             s_axi_arprot_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  // Low-power controls to the link
  output logic                        tx_l0s_en_o,
  output logic                        l1_en_o,
  output logic                        rx_l0s_allowed_o,
  // Link state controls
  output logic                        link_disable_o,
  output logic                        retrain_start_o,
  output logic                        common_clk_o,
  output logic                        hw_width_dis_o,
  output logic                        bw_mgmt_ie_o,
  output logic                        auto_bw_ie_o,
  // Low-power exit ordered sets
  input  wire logic                   exit_l0s_req_i,
  input  wire logic                   exit_l1_req_i,
  input  wire logic                   os_ready_i,
  output logic                        os_valid_o,
  output logic                        os_is_ts1_o
);

  // ============================================================
  // Elaboration checks
  initial
  begin
    if (NORM_FTS < 1 || NORM_FTS > 8191) $error("spl_link_ctl: NORM_FTS out of range");
    if (NORM_TS1 < 1 || NORM_TS1 > 8191) $error("spl_link_ctl: NORM_TS1 out of range");
  end

  // ============================================================
  // Helpers
  function automatic logic addr_hit(input logic [`SPL_ADDR_W-1:0] addr);
    addr_hit = (addr[`SPL_ADDR_W-1:2] == (`SPL_ADDR_W-2)'(`SPL_LINK_CTL_OFFSET >> 2));
  endfunction : addr_hit

  function automatic logic [15:0] read_value(input spl_link_ctl_s ctl);
    spl_link_ctl_s v;
    v            = ctl;
    v.rsvd_15_12 = 4'h0; // [R12]
    v.rsvd_8     = 1'b0; // [R12]
    v.rsvd_2     = 1'b0; // [R12]
    v.rcb        = 1'b0; // [R3]
    v.retrain    = 1'b0; // [R8]
    read_value   = v;
  endfunction : read_value

  // ============================================================
  // Declarations
  spl_link_ctl_s          ctl_ff;
  spl_state_e             wr_state_ff;
  spl_state_e             rd_state_ff;
  logic                   aw_held;
  logic                   w_held;
  logic [`SPL_ADDR_W-1:0] aw_addr;
  logic [35:0]            w_bundle;
  logic                   wr_do;
  logic                   wr_hit;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic                   wr_lo;
  logic                   wr_hi;
  logic                   rd_take;

  // ============================================================
  // Write channel capture, either order
  spl_hold #(
    .WIDTH (`SPL_ADDR_W)
  ) u_aw_hold (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .valid_i   (s_axi_awvalid_i),
    .data_i    (s_axi_awaddr_i),
    .ready_o   (s_axi_awready_o),
    .release_i (wr_do),
    .held_o    (aw_held),
    .data_o    (aw_addr)
  );

  spl_hold #(
    .WIDTH (36)
  ) u_w_hold (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .valid_i   (s_axi_wvalid_i),
    .data_i    ({s_axi_wstrb_i, s_axi_wdata_i}),
    .ready_o   (s_axi_wready_o),
    .release_i (wr_do),
    .held_o    (w_held),
    .data_o    (w_bundle)
  );

  assign wr_data = w_bundle[31:0];
  assign wr_strb = w_bundle[35:32];
  assign wr_do   = aw_held && w_held && (wr_state_ff == SPL_IDLE);
  assign wr_hit  = wr_do && addr_hit(aw_addr);
  assign wr_lo   = wr_hit && wr_strb[0];
  assign wr_hi   = wr_hit && wr_strb[1];

  // ============================================================
  // Write response
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_state_ff    <= SPL_IDLE;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `SPL_RESP_OKAY;
    end
    else
    begin
      case (wr_state_ff)
        SPL_IDLE:
        begin
          if (wr_do)
          begin
            wr_state_ff    <= SPL_BUSY;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= addr_hit(aw_addr) ? `SPL_RESP_OKAY : `SPL_RESP_DECERR;
          end
        end
        SPL_BUSY:
        begin
          if (s_axi_bready_i)
          begin
            wr_state_ff    <= SPL_IDLE;
            s_axi_bvalid_o <= 1'b0;
          end
        end
        default:
        begin
          wr_state_ff    <= SPL_IDLE;
          s_axi_bvalid_o <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // Low-power entry field
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctl_ff.aspm <= SPL_ASPM_OFF; // [R13]
    else if (wr_lo)
      ctl_ff.aspm <= wr_data[`SPL_BIT_ASPM_LO +: 2]; // [R1]
  end

  // ============================================================
  // Link disable
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctl_ff.link_disable <= 1'b0; // [R13]
    else if (IS_UPSTREAM)
      ctl_ff.link_disable <= 1'b0; // [R4]
    else if (wr_lo)
      ctl_ff.link_disable <= wr_data[`SPL_BIT_LINK_DIS]; // [R5]
  end

  // ============================================================
  // Retrain start pulse, never stored
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctl_ff.retrain <= 1'b0; // [R13]
    else
      ctl_ff.retrain <= !IS_UPSTREAM && wr_lo && wr_data[`SPL_BIT_RETRAIN]; // [R6] [R7]
  end

  // ============================================================
  // Clocking and synchronisation options
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_ff.common_clk <= 1'b0; // [R13]
      ctl_ff.ext_synch  <= 1'b0; // [R13]
    end
    else if (wr_lo)
    begin
      ctl_ff.common_clk <= wr_data[`SPL_BIT_COMMON_CLK]; // [R9]
      ctl_ff.ext_synch  <= wr_data[`SPL_BIT_EXT_SYNCH];
    end
  end

  // ============================================================
  // Width control and bandwidth interrupt enables
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_ff.hw_width_dis <= 1'b0; // [R13]
      ctl_ff.bw_mgmt_ie   <= 1'b0; // [R13]
      ctl_ff.auto_bw_ie   <= 1'b0; // [R13]
    end
    else if (wr_hi)
    begin
      ctl_ff.hw_width_dis <= wr_data[`SPL_BIT_HW_WIDTH];
      if (!IS_UPSTREAM)
      begin
        ctl_ff.bw_mgmt_ie <= wr_data[`SPL_BIT_BW_MGMT_IE]; // [R11]
        ctl_ff.auto_bw_ie <= wr_data[`SPL_BIT_AUTO_BW_IE]; // [R11]
      end
    end
  end

  // ============================================================
  // Bits with no storage
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_ff.rsvd_15_12 <= 4'h0;
      ctl_ff.rsvd_8     <= 1'b0;
      ctl_ff.rcb        <= 1'b0;
      ctl_ff.rsvd_2     <= 1'b0;
    end
    else
    begin
      ctl_ff.rsvd_15_12 <= 4'h0; // [R12]
      ctl_ff.rsvd_8     <= 1'b0; // [R12]
      ctl_ff.rcb        <= 1'b0; // [R3]
      ctl_ff.rsvd_2     <= 1'b0; // [R12]
    end
  end

  // ============================================================
  // Read channel
  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_state_ff     <= SPL_IDLE;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `SPL_RESP_OKAY;
    end
    else
    begin
      case (rd_state_ff)
        SPL_IDLE:
        begin
          if (rd_take)
          begin
            rd_state_ff     <= SPL_BUSY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            if (addr_hit(s_axi_araddr_i))
            begin
              s_axi_rdata_o <= {16'h0000, read_value(ctl_ff)};
              s_axi_rresp_o <= `SPL_RESP_OKAY;
            end
            else
            begin
              s_axi_rdata_o <= 32'h0000_0000;
              s_axi_rresp_o <= `SPL_RESP_DECERR;
            end
          end
        end
        SPL_BUSY:
        begin
          if (s_axi_rready_i)
          begin
            rd_state_ff     <= SPL_IDLE;
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
          end
        end
        default:
        begin
          rd_state_ff     <= SPL_IDLE;
          s_axi_arready_o <= 1'b1;
          s_axi_rvalid_o  <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // Link-side controls
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_l0s_en_o      <= 1'b0;
      l1_en_o          <= 1'b0;
      rx_l0s_allowed_o <= 1'b1;
      link_disable_o   <= 1'b0;
      common_clk_o     <= 1'b0;
      hw_width_dis_o   <= 1'b0;
      bw_mgmt_ie_o     <= 1'b0;
      auto_bw_ie_o     <= 1'b0;
    end
    else
    begin
      tx_l0s_en_o      <= ctl_ff.aspm[0]; // [R1]
      l1_en_o          <= ctl_ff.aspm[1]; // [R1]
      rx_l0s_allowed_o <= 1'b1; // [R2]
      link_disable_o   <= ctl_ff.link_disable; // [R5]
      common_clk_o     <= ctl_ff.common_clk; // [R9]
      hw_width_dis_o   <= ctl_ff.hw_width_dis;
      bw_mgmt_ie_o     <= ctl_ff.bw_mgmt_ie;
      auto_bw_ie_o     <= ctl_ff.auto_bw_ie;
    end
  end

  assign retrain_start_o = ctl_ff.retrain;

  // ============================================================
  // Ordered sets on leaving low-power states
  spl_os_seq #(
    .NORM_FTS (NORM_FTS),
    .NORM_TS1 (NORM_TS1)
  ) u_os_seq (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .ext_synch_i (ctl_ff.ext_synch),
    .exit_l0s_i  (exit_l0s_req_i),
    .exit_l1_i   (exit_l1_req_i),
    .os_ready_i  (os_ready_i),
    .os_valid_o  (os_valid_o),
    .os_is_ts1_o (os_is_ts1_o)
  );

endmodule : spl_link_ctl

/* spl_link_ctl_props.sv */
/*
  Checker of the port link control block: readback zeros, link control
  outputs and ordered-set bursts.
  Sees only the top module's ports; bound to every instance below.
*/
module spl_link_ctl_props
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  // Bus answers
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  // Link controls
  input wire logic        tx_l0s_en_o,
  input wire logic        l1_en_o,
  input wire logic        rx_l0s_allowed_o,
  input wire logic        link_disable_o,
  input wire logic        retrain_start_o,
  input wire logic        common_clk_o,
  // Ordered sets
  input wire logic        exit_l0s_req_i,
  input wire logic        exit_l1_req_i,
  input wire logic        os_ready_i,
  input wire logic        os_valid_o,
  input wire logic        os_is_ts1_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // ============================================================
  // Properties
  rx_l0s_on_a : assert property (rx_l0s_allowed_o)
    else $error("Receiver low-power entry not allowed");
  rsvd_zero_a : assert property (s_axi_rvalid_o |-> (s_axi_rdata_o & 32'hffff_f12c) == 0)
    else $error("Fixed-zero bits read as one");
  retrain_pulse_a : assert property (retrain_start_o |=> !retrain_start_o)
    else $error("Retrain request longer than one cycle");
  retrain_cause_a : assert property (retrain_start_o |-> s_axi_bvalid_o && s_axi_bresp_o == 2'h0)
    else $error("Retrain request without an accepted write");
  disable_cause_a : assert property ($changed(link_disable_o) |-> $past(s_axi_bvalid_o))
    else $error("Link disable changed without a write");
  aspm_cause_a : assert property ($changed({tx_l0s_en_o, l1_en_o}) |->
    $past(s_axi_bvalid_o) && $past(s_axi_bresp_o) == 2'h0)
    else $error("Low-power enables changed without a write");
  common_clk_a : assert property ($changed(common_clk_o) |-> $past(s_axi_bvalid_o))
    else $error("Common clock flag changed without a write");
  os_start_a : assert property ($rose(os_valid_o) |->
    $past(exit_l0s_req_i) || $past(exit_l1_req_i))
    else $error("Ordered-set burst without a request");
  os_kind_a : assert property ($rose(os_valid_o) |->
    os_is_ts1_o == (!$past(exit_l0s_req_i) && $past(exit_l1_req_i)))
    else $error("Ordered-set kind wrong at burst start");
  os_hold_a : assert property (os_valid_o && !os_ready_i |=> os_valid_o && $stable(os_is_ts1_o))
    else $error("Ordered set dropped while stalled");
endmodule : spl_link_ctl_props

bind spl_link_ctl spl_link_ctl_props i_props (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .tx_l0s_en_o(tx_l0s_en_o), .l1_en_o(l1_en_o),
  .rx_l0s_allowed_o(rx_l0s_allowed_o), .link_disable_o(link_disable_o),
  .retrain_start_o(retrain_start_o), .common_clk_o(common_clk_o),
  .exit_l0s_req_i(exit_l0s_req_i), .exit_l1_req_i(exit_l1_req_i),
  .os_ready_i(os_ready_i), .os_valid_o(os_valid_o), .os_is_ts1_o(os_is_ts1_o)
);

/* spl_link_peer.sv */
/*
  Link-side consumer of ordered sets: takes a set in each cycle after one with
  stall_i low, and counts the sets taken. Assumes stall_i changes after the edge.
*/
module spl_link_peer
(
  // Clock and reset
  input  wire logic   sys_clk_i,
  input  wire logic   reset_n_i,
  // Ordered sets
  input  wire logic   os_valid_i,
  input  wire logic   stall_i,
  output logic        os_ready_o,
  output logic [31:0] sets_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ============================================================
  // Acceptance and count
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      os_ready_o <= 1'h0;
      sets_o     <= 32'h0000_0000;
    end
    else
    begin
      os_ready_o <= !stall_i;
      if (os_valid_i && os_ready_o)
        sets_o <= sets_o + 32'h0000_0001;
    end
  end
endmodule : spl_link_peer

/* testbench.sv */
/*
  Self-checking bench of the port link control block on a downstream port.
  Assumes the bound checker and the link peer model beside it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ============================================================
  // Signals
  logic        clk = 1'h0, reset_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, req_l0s = 1'h0, req_l1 = 1'h0, stall = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rd = 32'h0000_aef8, rdata, sets, s0, w, nr0;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, os_ready, os_valid, os_ts1, t1;
  logic        tx_l0s, l1_en, rx_l0s, link_dis, retrain, com_clk, hw_w, bw_ie, abw_ie;
  logic        ov_q = 1'h0;
  logic [33:0] rq[$], e34;
  logic [1:0]  bq[$];
  logic [32:0] oq[$], e33;
  logic [15:0] ex;
  int          n_mismatch = 0, cmp_count = 0, n_retrain = 0, cyc = 0;

  initial forever #20 clk = ~clk;

  spl_link_ctl #(.IS_UPSTREAM(1'b0), .NORM_FTS(3), .NORM_TS1(2)) i_dut (
    .sys_clk_i(clk), .reset_n_i(reset_n), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .tx_l0s_en_o(tx_l0s), .l1_en_o(l1_en),
    .rx_l0s_allowed_o(rx_l0s), .link_disable_o(link_dis), .retrain_start_o(retrain),
    .common_clk_o(com_clk), .hw_width_dis_o(hw_w), .bw_mgmt_ie_o(bw_ie),
    .auto_bw_ie_o(abw_ie), .exit_l0s_req_i(req_l0s), .exit_l1_req_i(req_l1),
    .os_ready_i(os_ready), .os_valid_o(os_valid), .os_is_ts1_o(os_ts1));

  spl_link_peer i_peer (.sys_clk_i(clk), .reset_n_i(reset_n), .os_valid_i(os_valid),
    .stall_i(stall), .os_ready_o(os_ready), .sets_o(sets));

  // ============================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bq.push_back(er);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bready && bvalid) bready <= 1'h0;
    end
    while (awvalid || wvalid || bready);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rready && rvalid) rready <= 1'h0;
    end
    while (arvalid || rready);
  endtask : rd_reg

  task automatic burst(input logic l0s, input logic l1, input logic [32:0] e);
    int t;
    oq.push_back(e);
    req_l0s <= l0s;
    req_l1  <= l1;
    @(posedge clk);
    req_l0s <= 1'h0;
    req_l1  <= 1'h0;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (os_valid || t < 3);
    @(posedge clk);
  endtask : burst

  // ============================================================
  // Result monitor, stall pattern and watchdog
  always @(posedge clk)
  begin
    cyc++;
    stall <= (cyc[1:0] == 2'h3);
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
    if (retrain) n_retrain++;
    if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready)
    begin
      e34 = rq.pop_front();
      check({30'h0, rresp}, {30'h0, e34[33:32]});
      check(rdata, e34[31:0]);
    end
    if (os_valid && !ov_q)
    begin
      s0 = sets;
      t1 = os_ts1;
    end
    if (!os_valid && ov_q)
    begin
      e33 = oq.pop_front();
      check(sets - s0, e33[31:0]);
      check({31'h0, t1}, {31'h0, e33[32]});
    end
    ov_q = os_valid;
  end

  // ============================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    check({23'h0, rx_l0s, tx_l0s, l1_en, link_dis, retrain, com_clk, hw_w, bw_ie, abw_ie},
          32'h0000_0100);
    rd_reg(12'h0d0, 34'h0_0000_0000);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      rd  = xs(rd);
      w   = {rd[31:6], i[0], i[1], rd[3:2], i[1:0]};
      nr0 = n_retrain;
      wr_reg(12'h0d0, w, 4'hf, 2'h0);
      ex = w[15:0] & 16'h0ed3;
      rd_reg(12'h0d0, {18'h0, ex});
      check({25'h0, tx_l0s, l1_en, link_dis, com_clk, hw_w, bw_ie, abw_ie},
            {25'h0, w[0], w[1], w[4], w[6], w[9], w[10], w[11]});
      check(n_retrain, nr0 + w[5]);
    end
    $display("Test field write and readback done");
    nr0 = n_retrain;
    wr_reg(12'h0d0, 32'hffff_ffff, 4'h2, 2'h0);
    ex = (ex & 16'h00d3) | 16'h0e00;
    rd_reg(12'h0d0, {18'h0, ex});
    check(n_retrain, nr0);
    wr_reg(12'h0d4, 32'hffff_ffff, 4'hf, 2'h3);
    rd_reg(12'h0d4, 34'h3_0000_0000);
    rd_reg(12'h0d0, {18'h0, ex});
    $display("Test strobes and unmapped address done");
    wr_reg(12'h0d0, 32'h0000_0000, 4'hf, 2'h0);
    burst(1'h1, 1'h0, 33'h0_0000_0003);
    burst(1'h0, 1'h1, 33'h1_0000_0002);
    burst(1'h1, 1'h1, 33'h0_0000_0003);
    wr_reg(12'h0d0, 32'h0000_0080, 4'hf, 2'h0);
    burst(1'h1, 1'h0, 33'h0_0000_1000);
    burst(1'h0, 1'h1, 33'h1_0000_0400);
    $display("Test ordered-set bursts done");
    stop_test();
  end
endmodule : testbench
